// [hdl/status_flags_pkg.sv]
// Overview of operation
// - the status register answers at data offset 0x03 and at 0x83, both the same flip-flops.
// - direct addressing uses the lower bank bit, 0 for bank 0 (00h-7Fh) and 1 for bank 1 (80h-FFh).
// - each bank spans 128 bytes and the bank bit sits directly above the seven direct bits.
// - add and subtract update digit carry from the low nibble, with borrow meaning inverted on subtract.
// - the carry flag shows a carry out of the result's top bit on an add.
// - subtraction adds the two's complement of the second operand, so a borrow reads as 0.
// - rotates load carry with the bit shifted out, low bit for right and high bit for left.
// - after power-on the lower bank bit reads 0 and the time-out and power-down flags read 1.
// - a flag-updating instruction aimed at the status register keeps its flags, and time-out
//         and power-down are never writable.
package status_flags_pkg;
    localparam int WB_ADR_W = 10;
    localparam int WB_DAT_W = 32;
    localparam logic [7:0] STATUS_IDX_BANK0 = 8'h03;
    localparam logic [7:0] STATUS_IDX_BANK1 = 8'h83;
    localparam int BANK_SIZE = 128;
    localparam int DIRECT_W = $clog2(BANK_SIZE);
    localparam int BIT_INDIRECT_BANK = 7;
    localparam int BIT_BANK_HIGH = 6;
    localparam int BIT_BANK_LOW = 5;
    localparam int BIT_TIMEOUT = 4;
    localparam int BIT_POWERDOWN = 3;
    localparam int BIT_ZERO = 2;
    localparam int BIT_DIGIT_CARRY = 1;
    localparam int BIT_CARRY = 0;
    // power-on value; arithmetic flags are unknown on the part and start at zero here
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] NIBBLE_MASK = 8'h0f;

    typedef enum logic [2:0] {
        OP_MOVE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_ROT_RIGHT, OP_ROT_LEFT
    } alu_op_t;

    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic [7:0] first;
        logic [7:0] second;
        logic dest_status;
    } alu_req_t;

    typedef struct packed {
        logic zero;
        logic digit_carry;
        logic carry;
    } flags_t;
endpackage

// [hdl/alu_flag_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module alu_flag_unit
    import status_flags_pkg::*;
(
    input wire alu_req_t req_in,
    input wire logic carry_in,
    output logic [7:0] result_out,
    output flags_t flags_out,
    output flags_t update_out
);
    wire logic [7:0] addend;
    wire logic [8:0] sum;
    wire logic [4:0] low_sum;
    wire logic is_arith;

    // subtract = first + ~second + 1, so a borrow leaves carry at 0
    assign addend = (req_in.op == OP_SUB) ? ~req_in.second : req_in.second;
    assign sum = {1'b0, req_in.first} + {1'b0, addend} + {8'h00, req_in.op == OP_SUB};
    assign low_sum = {1'b0, req_in.first[3:0]} + {1'b0, addend[3:0]}
                     + {4'h0, req_in.op == OP_SUB};
    assign is_arith = (req_in.op == OP_ADD) || (req_in.op == OP_SUB);

    always_comb begin
        unique case (req_in.op)
            OP_ADD, OP_SUB: result_out = sum[7:0];
            OP_AND: result_out = req_in.first & req_in.second;
            OP_OR: result_out = req_in.first | req_in.second;
            OP_XOR: result_out = req_in.first ^ req_in.second;
            OP_ROT_RIGHT: result_out = {carry_in, req_in.first[7:1]};
            OP_ROT_LEFT: result_out = {req_in.first[6:0], carry_in};
            OP_MOVE: result_out = req_in.first;
        endcase
    end

    assign flags_out.zero = (result_out == 8'h00);
    assign flags_out.digit_carry = low_sum[4];
    assign flags_out.carry = (req_in.op == OP_ROT_RIGHT) ? req_in.first[0] :
                             (req_in.op == OP_ROT_LEFT) ? req_in.first[7] : sum[8];
    assign update_out.zero = req_in.valid && (is_arith || req_in.op == OP_AND
                             || req_in.op == OP_OR || req_in.op == OP_XOR);
    assign update_out.digit_carry = req_in.valid && is_arith;
    assign update_out.carry = req_in.valid && (is_arith || req_in.op == OP_ROT_RIGHT
                              || req_in.op == OP_ROT_LEFT);
endmodule
`default_nettype wire

// [hdl/status_flags.sv]
`timescale 1ns/1ps
`default_nettype none
module status_flags
    import status_flags_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [WB_ADR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [WB_DAT_W-1:0] wb_dat_in,
    output logic [WB_DAT_W-1:0] wb_dat_out,
    output logic wb_ack_out,
    input wire alu_req_t alu_req_in,
    input wire logic direct_valid_in,
    input wire logic [DIRECT_W-1:0] direct_addr_in,
    input wire logic watchdog_clear_in,
    input wire logic sleep_in,
    input wire logic watchdog_timeout_in,
    output logic [7:0] alu_result_out,
    output logic [7:0] status_out,
    output logic [DIRECT_W:0] bank_addr_out
);
    function automatic logic is_status(input logic [7:0] idx);
        return (idx == STATUS_IDX_BANK0) || (idx == STATUS_IDX_BANK1);
    endfunction

    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic ack_r;
    logic [WB_DAT_W-1:0] rdata_r;
    logic [7:0] result_r;
    logic [DIRECT_W:0] bank_addr_r;

    wire logic [7:0] reg_idx;
    wire logic bus_req;
    wire logic bus_hit;
    wire logic status_write;
    wire logic [7:0] alu_result;
    wire flags_t alu_flags;
    wire flags_t alu_update;
    wire logic alu_to_status;

    assign reg_idx = wb_adr_in[9:2];
    assign bus_req = wb_cyc_in && wb_stb_in && !ack_r;
    assign bus_hit = is_status(reg_idx);
    assign status_write = bus_req && wb_we_in && wb_sel_in[0] && bus_hit;
    assign alu_to_status = alu_req_in.valid && alu_req_in.dest_status;

    alu_flag_unit u_flags (
        .req_in(alu_req_in),
        .carry_in(status_r[BIT_CARRY]),
        .result_out(alu_result),
        .flags_out(alu_flags),
        .update_out(alu_update)
    );

    always_comb begin
        status_nxt = status_r;
        // bank bits and arithmetic flags take plain data writes
        if (status_write) begin
            status_nxt[7:5] = wb_dat_in[7:5];
            status_nxt[2:0] = wb_dat_in[2:0];
        end
        if (alu_to_status) begin
            status_nxt[7:5] = alu_result[7:5];
            status_nxt[2:0] = alu_result[2:0];
        end
        // flag results override any data write aimed at the same bits
        if (alu_update.zero) begin
            status_nxt[BIT_ZERO] = alu_flags.zero;
        end
        if (alu_update.digit_carry) begin
            status_nxt[BIT_DIGIT_CARRY] = alu_flags.digit_carry;
        end
        if (alu_update.carry) begin
            status_nxt[BIT_CARRY] = alu_flags.carry;
        end
        // time-out and power-down follow only their events; watchdog clear wins
        if (watchdog_timeout_in) begin
            status_nxt[BIT_TIMEOUT] = 1'b0;
        end
        if (sleep_in) begin
            status_nxt[BIT_TIMEOUT] = 1'b1;
            status_nxt[BIT_POWERDOWN] = 1'b0;
        end
        if (watchdog_clear_in) begin
            status_nxt[BIT_TIMEOUT] = 1'b1;
            status_nxt[BIT_POWERDOWN] = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_r <= STATUS_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= bus_req;
            if (bus_req) begin
                rdata_r <= bus_hit ? {24'h00_0000, status_r} : '0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            result_r <= 8'h00;
            bank_addr_r <= '0;
        end else begin
            if (alu_req_in.valid) begin
                result_r <= alu_result;
            end
            if (direct_valid_in) begin
                bank_addr_r <= {status_r[BIT_BANK_LOW], direct_addr_in};
            end
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_dat_out = rdata_r;
    assign alu_result_out = result_r;
    assign status_out = status_r;
    assign bank_addr_out = bank_addr_r;

    sequence bus_read_s;
        bus_req && !wb_we_in && bus_hit;
    endsequence

    sequence add_op_s;
        alu_req_in.valid && alu_req_in.op == OP_ADD && !watchdog_clear_in;
    endsequence

    property status_mirror_p;
        @(posedge clk_in) disable iff (!resetn_in)
        bus_read_s |=> wb_ack_out && wb_dat_out[7:0] == $past(status_r);
    endproperty

    status_mirror_a: assert property (status_mirror_p)
        else $error("status read does not return the register");

    bank_addr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        direct_valid_in |=> bank_addr_out == {$past(status_r[BIT_BANK_LOW]), $past(direct_addr_in)})
        else $error("bank address not formed from bank bit");

    bank_span_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        direct_valid_in && status_r[BIT_BANK_LOW] |=> bank_addr_out >= 8'h80)
        else $error("bank one address below its span");

    timeout_set_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        watchdog_clear_in || sleep_in |=> status_out[BIT_TIMEOUT])
        else $error("time-out flag not set");

    timeout_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        watchdog_timeout_in && !watchdog_clear_in && !sleep_in |=> !status_out[BIT_TIMEOUT])
        else $error("time-out flag not cleared");

    powerdown_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        sleep_in && !watchdog_clear_in |=> !status_out[BIT_POWERDOWN])
        else $error("power-down flag not cleared by sleep");

    zero_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        alu_update.zero |=> status_out[BIT_ZERO] == (alu_result_out == 8'h00))
        else $error("zero flag does not match result");

    add_carry_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        add_op_s |=> status_out[BIT_CARRY] ==
            ({1'b0, $past(alu_req_in.first)} + {1'b0, $past(alu_req_in.second)} > 9'h0ff))
        else $error("carry flag wrong after add");

    digit_carry_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        alu_req_in.valid && alu_req_in.op == OP_ADD |=> status_out[BIT_DIGIT_CARRY] ==
            (($past(alu_req_in.first) & NIBBLE_MASK) + ($past(alu_req_in.second) & NIBBLE_MASK)
             > NIBBLE_MASK))
        else $error("digit carry wrong after add");

    sub_borrow_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        alu_req_in.valid && alu_req_in.op == OP_SUB |=>
            status_out[BIT_CARRY] == ($past(alu_req_in.first) >= $past(alu_req_in.second)))
        else $error("borrow polarity wrong after subtract");

    rotate_carry_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        alu_req_in.valid && alu_req_in.op == OP_ROT_RIGHT |=>
            status_out[BIT_CARRY] == $past(alu_req_in.first[0]))
        else $error("right rotate carry wrong");

    flag_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        status_write && alu_update.carry |=> status_out[BIT_CARRY] == $past(alu_flags.carry))
        else $error("data write overrode carry result");

    ack_pulse_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// [tb/status_flags_test.sv]
`timescale 1ns/1ps
`default_nettype none
module status_flags_test import status_flags_pkg::*; ;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, dv = 1'b0;
    logic wclr = 1'b0, slp = 1'b0, wto = 1'b0;
    logic [WB_ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [WB_DAT_W-1:0] wdat = '0;
    logic [WB_DAT_W-1:0] rdat;
    logic ack;
    logic [6:0] da = 7'h00;
    alu_req_t req = '0;
    logic [7:0] alu_res, status, st;
    logic [DIRECT_W:0] bank_adr;
    logic [31:0] lf = 32'h0000_81ce;
    logic [31:0] rd;
    int err_count = 0;
    int check_count = 0;

    always #4 clk_in = ~clk_in;

    status_flags dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .alu_req_in(req), .direct_valid_in(dv),
        .direct_addr_in(da), .watchdog_clear_in(wclr), .sleep_in(slp),
        .watchdog_timeout_in(wto), .alu_result_out(alu_res), .status_out(status),
        .bank_addr_out(bank_adr));

    function automatic logic [31:0] next_lf(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // packs result, update mask and flag values {zero, digit carry, carry}
    function automatic logic [13:0] model(input alu_op_t op, input logic [7:0] a, b,
                                          input logic ci);
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] r;
        s = {1'b0, a} + {1'b0, b};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        if (op == OP_SUB) begin
            s = {1'b0, a} + {1'b0, ~b} + 9'h001;
            n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        end
        case (op)
            OP_ADD, OP_SUB: return {s[7:0], 3'b111, s[7:0] == 8'h00, n[4], s[8]};
            OP_AND: r = a & b;
            OP_OR: r = a | b;
            OP_XOR: r = a ^ b;
            OP_ROT_RIGHT: return {ci, a[7:1], 3'b001, 2'b00, a[0]};
            OP_ROT_LEFT: return {a[6:0], ci, 3'b001, 2'b00, a[7]};
            default: return {a, 6'h00};
        endcase
        return {r, 3'b100, r == 8'h00, 2'b00};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [WB_ADR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= d;
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        check(n, 32'h0000_0002);
    endtask

    // 0 clear, 1 sleep, 2 time-out, 3 direct address, 4 alu request
    task automatic strobe(input int k);
        @(posedge clk_in);
        wclr <= (k == 0);
        slp <= (k == 1);
        wto <= (k == 2);
        dv <= (k == 3);
        req.valid <= (k == 4);
        @(posedge clk_in);
        wclr <= 1'b0;
        slp <= 1'b0;
        wto <= 1'b0;
        dv <= 1'b0;
        req.valid <= 1'b0;
        @(negedge clk_in);
    endtask

    task automatic give_verdict;
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_in);
        err_count++;
        give_verdict;
    end

    initial begin
        logic [13:0] m;
        alu_op_t op;
        logic [7:0] a, b;
        logic d;
        logic [7:0] ca [4] = '{8'hff, 8'h0f, 8'h00, 8'h10};
        logic [7:0] cb [4] = '{8'h01, 8'h01, 8'h00, 8'h01};
        int ev [6] = '{1, 2, 0, 2, 1, 0};
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(negedge clk_in);
        check(status, 8'h18);
        st = 8'h18;
        wb(1'b0, 10'h20c, 32'h0);
        check(rd, 32'h0000_0018);
        wb(1'b1, 10'h20c, 32'h0000_0027);
        st = 8'h3f;
        wb(1'b0, 10'h00c, 32'h0);
        check(rd, {24'h00_0000, st});
        wb(1'b1, 10'h010, 32'h0000_00ff);
        wb(1'b0, 10'h010, 32'h0);
        check(rd, 32'h0);
        check(status, st);
        for (int i = 0; i < 4; i++) begin
            lf = next_lf(lf);
            wb(1'b1, 10'h00c, {26'h0, i[0], 5'h00});
            st = {2'b00, i[0], 5'h18};
            da <= (i < 2) ? 7'h7f : lf[6:0];
            strobe(3);
            check(bank_adr, {i[0], da});
        end
        foreach (ev[j]) begin
            strobe(ev[j]);
            st[4] = (ev[j] != 2);
            if (ev[j] < 2) st[3] = (ev[j] == 0);
            check(status, st);
        end
        for (int i = 0; i < 300; i++) begin
            lf = next_lf(lf);
            op = alu_op_t'(lf[2:0]);
            if (i < 4) op = i[1] ? OP_SUB : OP_ADD;
            if (i == 4) op = OP_ADD;
            a = (i < 4) ? ca[i] : lf[15:8];
            b = (i < 4) ? cb[i] : lf[23:16];
            m = model(op, a, b, st[0]);
            d = lf[24] && (op == OP_ADD || op == OP_SUB) && m[13:12] == 2'b00;
            if (i == 4) d = 1'b0;
            @(posedge clk_in);
            req.op <= op;
            req.first <= a;
            req.second <= b;
            req.dest_status <= d;
            if (i == 4) begin
                // bus write of the flags lands on the same edge as an add
                fork
                    wb(1'b1, 10'h00c, 32'h0000_0007);
                    strobe(4);
                join
                @(negedge clk_in);
                st[7:5] = 3'b000;
            end else begin
                strobe(4);
            end
            st[2:0] = (m[5:3] & m[2:0]) | (~m[5:3] & st[2:0]);
            if (d) st[7:5] = m[13:11];
            check(alu_res, m[13:6]);
            check(status, st);
        end
        give_verdict;
    end
endmodule
`default_nettype wire
